/* rtl/cle_executor.sv */
// Instruction executor of a character display controller with a Wishbone register port.
`timescale 1ns/100ps

// Function
// (RL1) Control byte continuation flag zero marks last
// (RL2) Two-line bit: 24x1 or 12x2, ignored under 1:9
// (RL3) Single-line mux bit: 1:18 or 1:9 12x1
// (RL4) Page bit picks basic or extended instructions
// (RL5) Mirror bit reverses halves, only 24x1
// (RL6) Column-order bit reverses column output order
// (RL7) Row-order bit reverses rows and icon rows
// (RL8) Icon-only bit shows icons only; here it only hides cursor and blink
// (RL9) Blink bit blinks character at cursor
// (RL10) Clear fills 20h, zero counter, unshift
// (RL11) Clear sets increment, keeps shift setting
// (RL12) Clear takes 165 cycles
// (RL13) Home zeroes counter, unshifts, keeps rest
// (RL14) Data access steps counter by direction
// (RL15) Cursor and blink hidden during glyph access
// (RL16) Shift-enabled display writes shift display
// (RL17) No shift on reads or glyph access
// (RL18) Display-on bit keeps RAM contents
// (RL19) Display off powers down outputs, generators
// (RL20) Three cycles settle after display off
// (RL21) Cursor-on shows underline on line eight
// (RL22) Hidden cursor keeps entry-mode stepping
// (RL23) Blink toggles at clock over 104448
// (RL24) Busy blocks further instructions
// (RL25) Busy covers whole instruction execution
module cle_executor
    import cle_pkg::*;
#(
    parameter int unsigned BLINK_DIV = CLE_BLINK_DIV
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic busy_indication_o,
    output logic outputs_grounded_o,
    output logic vgen_enable_o,
    output logic bias_enable_o,
    output logic osc_stop_ok_o,
    output logic blink_phase_o,
    output logic [6:0] address_counter_o,
    output logic [6:0] display_shift_o,
    output logic [14:0] layout_o
);

    // Everything runs on the one bus clock, so every execution time below is counted in
    // bus clocks; a slower oscillator would stretch them in proportion.

    // Lower half holds display characters, upper half the glyph patterns.
    logic [7:0] ram_q [CLE_RAM_WORDS];
    logic [6:0] ac_q;
    logic [6:0] shift_q;
    logic [7:0] rdata_q;
    logic [7:0] busy_cnt_q;
    logic [7:0] off_cnt_q;
    logic [6:0] clr_idx_q;
    logic [16:0] blink_cnt_q;
    logic blink_q;
    logic glyph_sel_q;
    logic last_ctrl_q;
    logic ctrl_rs_q;
    logic ack_q;
    logic [31:0] dat_q;
    // One-hot state; any other code falls back to idle.
    cle_state_t state_q;
    cle_cfg_t cfg_q;
    cle_mode_t mode_q;
    cle_layout_t lay;

    // A request is taken on the edge where it is seen with ack still low; the registered
    // ack then keeps the same bus cycle from being taken twice.
    wire logic req = wb_cyc_i && wb_stb_i && !ack_q;
    wire logic wr_lane0 = req && wb_we_i && wb_sel_i[0];

    // Command and data accesses are acknowledged but dropped while busy.
    wire logic busy = (state_q != CLE_IDLE);
    wire logic cmd_go = wr_lane0 && (wb_adr_i == CLE_OFF_CMD) && !busy; // RL24
    wire logic data_wr = wr_lane0 && (wb_adr_i == CLE_OFF_DATA) && !busy; // RL24
    wire logic data_rd = req && !wb_we_i && (wb_adr_i == CLE_OFF_DATA) && !busy; // RL24

    // Instruction decode. The page bit splits the low codes between the basic and the
    // extended set, so a code sent on the wrong page silently does something else.
    // Codes that match nothing still occupy the executor for the plain execution time.
    wire logic [7:0] cmd = wb_dat_i[7:0];
    wire logic basic_page = !cfg_q.ext_page; // RL4
    wire logic do_clear = cmd_go && basic_page && (cmd == 8'h01);
    wire logic do_home = cmd_go && basic_page && (cmd[7:1] == 7'h01);
    wire logic do_entry = cmd_go && basic_page && (cmd[7:2] == 6'h01);
    wire logic do_disp = cmd_go && basic_page && (cmd[7:3] == 5'h01);
    wire logic do_cgadr = cmd_go && basic_page && (cmd[7:6] == 2'b01);
    wire logic do_ddadr = cmd_go && (cmd[7] == 1'b1) && basic_page;
    // Extended page decodes reuse the low codes of the basic page.
    wire logic do_screen = cmd_go && !basic_page && (cmd[7:1] == 7'h01);
    wire logic do_dcfg = cmd_go && !basic_page && (cmd[7:2] == 6'h01);
    wire logic do_icon = cmd_go && !basic_page && (cmd[7:3] == 5'h01);
    // Function set is decoded on both pages; it is the only way back to the basic set.
    wire logic do_func = cmd_go && (cmd[7:5] == 3'b001);

    // Any accepted data access steps the address counter.
    wire logic data_acc = data_wr || data_rd;

    // Ram access: clear sweep has the port, otherwise the host data access.
    // A host write cannot collide with the sweep, since busy refuses it first.
    always_ff @(posedge clk_i) begin
        if (state_q == CLE_CLEAR) begin
            ram_q[clr_idx_q] <= CLE_BLANK_CHAR; // RL10
        end else if (data_wr) begin
            ram_q[ac_q] <= wb_dat_i[7:0];
        end
    end

    // The read latch is refilled on data reads and on both address commands, so a read
    // returns the word latched by the access before it. A write never touches the latch.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= 8'h00;
        end else if (data_rd || do_cgadr || do_ddadr) begin
            rdata_q <= ram_q[ac_q];
        end
    end

    // The sweep covers only the display half; glyph contents survive a clear.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= CLE_IDLE;
            busy_cnt_q <= 8'h00;
            clr_idx_q <= 7'h00;
        end else begin
            unique case (state_q)
                CLE_IDLE: begin
                    // Every command and data access holds busy for its execution time;
                    // status and other register reads do not.
                    if (do_clear) begin
                        state_q <= CLE_CLEAR;
                        clr_idx_q <= 7'h00;
                        busy_cnt_q <= CLE_CLEAR_CYCLES; // RL12
                    end else if (cmd_go || data_acc) begin
                        state_q <= CLE_WAIT;
                        busy_cnt_q <= CLE_CMD_CYCLES; // RL25
                    end
                end
                // The counter keeps running through the sweep, so the whole clear shows
                // busy for exactly the clear time and not the sweep plus a tail.
                CLE_CLEAR: begin
                    busy_cnt_q <= busy_cnt_q - 8'd1;
                    if (clr_idx_q == 7'(CLE_GLYPH_BASE - 1)) begin
                        state_q <= CLE_WAIT;
                    end else begin
                        clr_idx_q <= clr_idx_q + 7'd1;
                    end
                end
                // Leaves on the last counted cycle, so busy spans the full count.
                CLE_WAIT: begin
                    if (busy_cnt_q == 8'd1) begin
                        state_q <= CLE_IDLE; // RL25
                    end
                    busy_cnt_q <= busy_cnt_q - 8'd1;
                end
                default: begin
                    state_q <= CLE_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ac_q <= CLE_AC_RST;
            glyph_sel_q <= 1'b0;
        end else if (do_clear || do_home) begin
            ac_q <= CLE_AC_RST; // RL10 RL13
            glyph_sel_q <= 1'b0;
        end else if (do_cgadr) begin
            ac_q <= {ac_q[6], cmd[5:0]};
            glyph_sel_q <= 1'b1;
        end else if (do_ddadr) begin
            ac_q <= cmd[6:0];
            glyph_sel_q <= 1'b0;
        end else if (data_acc) begin
            // Stepping follows the entry direction whether or not the cursor is shown, and
            // wraps at both ends of the seven-bit counter.
            ac_q <= mode_q.incr ? ac_q + 7'd1 : ac_q - 7'd1; // RL14 RL22
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shift_q <= CLE_SHIFT_RST;
        end else if (do_clear || do_home) begin
            shift_q <= CLE_SHIFT_RST; // RL10 RL13
        end else if (data_wr && !glyph_sel_q && mode_q.shift_en) begin
            // A left shift moves the window forward and counts down; reads and glyph
            // writes never reach this branch.
            shift_q <= mode_q.incr ? shift_q - 7'd1 : shift_q + 7'd1; // RL16 RL17
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_q <= '0;
        end else begin
            if (do_clear) begin
                // Clear forces increment but leaves the shift setting alone.
                mode_q.incr <= 1'b1; // RL11
            end else if (do_entry) begin
                mode_q.incr <= cmd[1];
                mode_q.shift_en <= cmd[0];
            end
            if (do_disp) begin
                mode_q.display_on <= cmd[2]; // RL18
                mode_q.cursor_on <= cmd[1];
                mode_q.blink_on <= cmd[0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_q <= '0;
        end else begin
            // Geometry bits only change the decoded layout; the character memory and
            // the address counter are left as they are.
            if (do_func) begin
                cfg_q.two_line <= cmd[2];
                cfg_q.single_line_mux <= cmd[1];
                cfg_q.ext_page <= cmd[0]; // RL4
            end
            if (do_screen) begin
                cfg_q.mirror <= cmd[0];
            end
            if (do_dcfg) begin
                cfg_q.col_rev <= cmd[1];
                cfg_q.row_rev <= cmd[0];
            end
            if (do_icon) begin
                cfg_q.icon_only <= cmd[2];
            end
        end
    end

    // Host writes a control byte; the two flags steer whether the next byte is data.
    // Nothing here acts on them yet; they are only reported in the status word.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last_ctrl_q <= 1'b1;
            ctrl_rs_q <= 1'b0;
        end else if (wr_lane0 && wb_adr_i == CLE_OFF_CTRLBYTE) begin
            last_ctrl_q <= !wb_dat_i[CLE_CB_CONT]; // RL1
            ctrl_rs_q <= wb_dat_i[CLE_CB_RS];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            off_cnt_q <= 8'h00;
        end else if (mode_q.display_on || (do_disp && cmd[2])) begin
            off_cnt_q <= 8'h00;
        end else if (off_cnt_q != CLE_OFF_SETTLE_CYCLES) begin
            // The count saturates, so the flag stays up until the display is switched on
            // again and the oscillator may be stopped at any time after it.
            off_cnt_q <= off_cnt_q + 8'd1; // RL20
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            blink_cnt_q <= 17'h00000;
            blink_q <= 1'b0;
        end else if (blink_cnt_q == 17'(BLINK_DIV / 2 - 1)) begin
            blink_cnt_q <= 17'h00000;
            // Half the divider per phase gives one full blink period per divider count.
            blink_q <= !blink_q; // RL23
        end else begin
            blink_cnt_q <= blink_cnt_q + 17'd1;
        end
    end

    always_comb begin
        // Default everything first so no field can keep a stale value.
        lay = '0;
        lay.mux_1_9 = cfg_q.single_line_mux; // RL3
        lay.mux_1_18 = !cfg_q.single_line_mux;
        if (cfg_q.single_line_mux || cfg_q.two_line) begin
            lay.chars_per_line = 6'd12; // RL2
        end else begin
            lay.chars_per_line = 6'd24;
        end
        lay.lines = (cfg_q.two_line && !cfg_q.single_line_mux) ? 2'd2 : 2'd1; // RL2
        // Mirroring only matters for one line of 24 characters; there it folds into the
        // column order, so mirror and column order together cancel.
        lay.col_backward = cfg_q.col_rev ^ // RL6
            (cfg_q.mirror && !cfg_q.two_line && !cfg_q.single_line_mux); // RL5
        lay.row_backward = cfg_q.row_rev; // RL7
        lay.power_down = !mode_q.display_on; // RL19
        // Cursor and blink are suppressed from a glyph address command until a display address, clear or home.
        lay.cursor_visible = mode_q.cursor_on && !glyph_sel_q && !cfg_q.icon_only; // RL15 RL21
        lay.blink_visible = mode_q.blink_on && !glyph_sel_q && !cfg_q.icon_only; // RL9 RL15 RL8
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
        end else begin
            // Ack follows one cycle after the take for every offset, mapped or not.
            ack_q <= req;
            // Read data is built from the address of the cycle being taken and stands
            // together with ack in the following cycle.
            unique case (wb_adr_i)
                CLE_OFF_DATA: dat_q <= {24'h000000, rdata_q};
                CLE_OFF_STATUS: dat_q <= {21'h000000, osc_stop_ok_o, last_ctrl_q, ctrl_rs_q,
                    busy, ac_q};
                CLE_OFF_CONFIG: dat_q <= {20'h00000, mode_q, cfg_q};
                CLE_OFF_LAYOUT: dat_q <= {17'h00000, lay};
                default: dat_q <= 32'h00000000;
            endcase
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    // Busy is a plain view of the state register.
    assign busy_indication_o = busy; // RL24
    // Display off grounds the drivers and stops both generators together.
    assign outputs_grounded_o = !mode_q.display_on; // RL19
    assign vgen_enable_o = mode_q.display_on;
    assign bias_enable_o = mode_q.display_on;
    // High once the outputs have had their settling time after display off.
    assign osc_stop_ok_o = (off_cnt_q == CLE_OFF_SETTLE_CYCLES);
    // The blink phase is gated, so it stays low whenever blinking is not visible.
    assign blink_phase_o = blink_q && lay.blink_visible;

    // Plain register views for the display side, and the combinational layout decode.
    assign address_counter_o = ac_q;
    assign display_shift_o = shift_q;
    assign layout_o = lay;

endmodule

/* pkg/cle_pkg.sv */
// Package with constants, types and command encodings of the display instruction executor.
package cle_pkg;

    localparam int unsigned CLK_HZ = 200_000_000;

    // Bus register offsets (byte addresses).
    localparam logic [7:0] CLE_OFF_CMD = 8'h00;
    localparam logic [7:0] CLE_OFF_DATA = 8'h04;
    localparam logic [7:0] CLE_OFF_STATUS = 8'h08;
    localparam logic [7:0] CLE_OFF_CONFIG = 8'h0c;
    localparam logic [7:0] CLE_OFF_LAYOUT = 8'h10;
    localparam logic [7:0] CLE_OFF_CTRLBYTE = 8'h14;

    // Execution times in bus clock cycles.
    localparam logic [7:0] CLE_CLEAR_CYCLES = 8'd165;
    localparam logic [7:0] CLE_CMD_CYCLES = 8'd3;
    localparam logic [7:0] CLE_OFF_SETTLE_CYCLES = 8'd3;
    localparam int unsigned CLE_BLINK_DIV = 104448;

    localparam logic [7:0] CLE_BLANK_CHAR = 8'h20;
    localparam int unsigned CLE_RAM_WORDS = 128;
    localparam int unsigned CLE_GLYPH_BASE = 64;

    // Bit positions in the control byte.
    localparam int unsigned CLE_CB_CONT = 7;
    localparam int unsigned CLE_CB_RS = 6;

    // Reset values.
    localparam logic [6:0] CLE_AC_RST = 7'h00;
    localparam logic [6:0] CLE_SHIFT_RST = 7'h00;

    typedef struct packed {
        logic two_line;
        logic single_line_mux;
        logic ext_page;
        logic mirror;
        logic col_rev;
        logic row_rev;
        logic icon_only;
    } cle_cfg_t;

    typedef struct packed {
        logic display_on;
        logic cursor_on;
        logic blink_on;
        logic incr;
        logic shift_en;
    } cle_mode_t;

    typedef struct packed {
        logic [5:0] chars_per_line;
        logic [1:0] lines;
        logic mux_1_9;
        logic mux_1_18;
        logic col_backward;
        logic row_backward;
        logic power_down;
        logic cursor_visible;
        logic blink_visible;
    } cle_layout_t;

    typedef enum logic [2:0] {
        CLE_IDLE = 3'b001,
        CLE_CLEAR = 3'b010,
        CLE_WAIT = 3'b100
    } cle_state_t;

endpackage

/* tb/cle_executor_checker.sv */
// Concurrent checks on the ports of the display instruction executor.
`timescale 1ns/100ps
module cle_executor_checker
    import cle_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic busy_indication_o,
    input wire logic outputs_grounded_o,
    input wire logic vgen_enable_o,
    input wire logic bias_enable_o,
    input wire logic osc_stop_ok_o,
    input wire logic [6:0] address_counter_o,
    input wire logic [6:0] display_shift_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic tk;
    logic cd;
    logic [7:0] bcnt_q;
    assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign cd = wb_adr_i == CLE_OFF_CMD || wb_adr_i == CLE_OFF_DATA;
    // Counts how long busy has been high, so its whole span can be judged when it falls.
    always_ff @(posedge clk_i) begin
        if (rst_i || !busy_indication_o) begin
            bcnt_q <= 8'h00;
        end else if (bcnt_q != 8'hff) begin
            bcnt_q <= bcnt_q + 8'h01;
        end
    end
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    a_ack_answers: assert property (tk |=> wb_ack_o) else $error("request not answered");
    a_busy_starts: assert property (tk && wb_we_i && cd && !busy_indication_o |=> busy_indication_o)
        else $error("busy not raised");
    a_busy_span: assert property ($fell(busy_indication_o) |->
        bcnt_q == CLE_CLEAR_CYCLES || bcnt_q == CLE_CMD_CYCLES) else $error("busy span wrong");
    a_clear_effect: assert property (tk && wb_we_i && !busy_indication_o
        && wb_adr_i == CLE_OFF_CMD && wb_dat_i[7:0] == 8'h01 |=> busy_indication_o
        && address_counter_o == CLE_AC_RST && display_shift_o == CLE_SHIFT_RST)
        else $error("clear effect wrong");
    a_busy_refuses: assert property (tk && wb_we_i && cd && busy_indication_o
        |=> $stable(address_counter_o) && $stable(display_shift_o)) else $error("busy ignored");
    a_counter_step: assert property (tk && !busy_indication_o && wb_adr_i == CLE_OFF_DATA
        |=> (address_counter_o - $past(address_counter_o)) == 7'h01
        || (address_counter_o - $past(address_counter_o)) == 7'h7f) else $error("step wrong");
    a_power_down: assert property (outputs_grounded_o == !vgen_enable_o
        && bias_enable_o == vgen_enable_o) else $error("power-down outputs inconsistent");
    a_settle_time: assert property ($rose(outputs_grounded_o) |-> !osc_stop_ok_o
        ##[2:4] osc_stop_ok_o) else $error("settle flag timing wrong");
    c_clear: cover property ($fell(busy_indication_o) && bcnt_q == CLE_CLEAR_CYCLES);
    c_off: cover property ($rose(outputs_grounded_o));
    c_refused: cover property (tk && wb_we_i && cd && busy_indication_o);
endmodule
bind cle_executor cle_executor_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .busy_indication_o(busy_indication_o),
    .outputs_grounded_o(outputs_grounded_o), .vgen_enable_o(vgen_enable_o),
    .bias_enable_o(bias_enable_o), .osc_stop_ok_o(osc_stop_ok_o),
    .address_counter_o(address_counter_o), .display_shift_o(display_shift_o));

/* tb/cle_host_model.sv */
// Host model that reaches the executor through classic Wishbone cycles.
`timescale 1ns/100ps
module cle_host_model
    import cle_pkg::*;
(
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic [31:0] dat_i,
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [7:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o
);
    initial begin
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o <= 1'b0;
        adr_o <= 8'h00;
        sel_o <= 4'h0;
        dat_o <= 32'h0;
    end
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= a;
        sel_o <= 4'h1;
        dat_o <= d;
        do @(posedge clk_i); while (ack_i !== 1'b1);
        q = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        // Released lines are scrambled so a stale value is never mistaken for a request.
        adr_o <= ~a;
        dat_o <= ~d;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        xfer(1'b1, a, {24'h0, d}, q);
    endtask
    task rd(input logic [7:0] a, output logic [31:0] q);
        xfer(1'b0, a, 32'h0, q);
    endtask
    task idle();
        logic [31:0] s;
        s = 32'h80;
        while (s[7] !== 1'b0) xfer(1'b0, CLE_OFF_STATUS, 32'h0, s);
    endtask
    task cmd(input logic [7:0] c);
        idle();
        wr(CLE_OFF_CMD, c);
    endtask
    task dwr(input logic [7:0] d);
        idle();
        wr(CLE_OFF_DATA, d);
    endtask
endmodule

/* tb/cle_executor_tb.sv */
// Self-checking testbench of the display instruction executor.
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module cle_executor_tb
    import cle_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc, stb, we, ack, busy, gnd, vgen, bias, stop_ok, blink;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q;
    logic [6:0] ac, shift;
    logic [14:0] layout;
    logic blink_was;
    int n_fail = 0;
    int check_count = 0;
    int cyc_n = 0;
    logic [7:0] cfg_cmd [9] = '{8'h21, 8'h03, 8'h06, 8'h0c, 8'h20, 8'h26, 8'h25, 8'h05, 8'h20};
    logic [6:0] cfg_exp [9] = '{7'h10, 7'h18, 7'h1c, 7'h1d, 7'h0d, 7'h6d, 7'h5d, 7'h5b, 7'h0b};
    logic [14:0] lay_exp [9] = '{15'h30a4, 15'h30b4, 15'h30a4, 15'h30a4, 15'h30a4, 15'h18d4,
        15'h1934, 15'h192c, 15'h30bc};
    always #2.5 clk_i = ~clk_i;
    cle_host_model u_host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
        .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
    cle_executor #(.BLINK_DIV(16)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .busy_indication_o(busy), .outputs_grounded_o(gnd),
        .vgen_enable_o(vgen), .bias_enable_o(bias), .osc_stop_ok_o(stop_ok),
        .blink_phase_o(blink), .address_counter_o(ac), .display_shift_o(shift),
        .layout_o(layout));
    task results();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // The whole sequence needs well under a thousand cycles; the ceiling of 20000 leaves ample margin.
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            n_fail++;
            results();
        end
    end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        `CHK({gnd, vgen, bias, stop_ok}, 4'b1001)
        u_host.rd(CLE_OFF_STATUS, q);
        `CHK(q[7:0], 8'h00)
        u_host.rd(CLE_OFF_CONFIG, q);
        `CHK(q[11:0], 12'h000)
        u_host.rd(8'h20, q);
        `CHK(q, 32'h0)
        $display("test reset done");
        u_host.cmd(8'h0c);
        u_host.cmd(8'h06);
        u_host.cmd(8'h85);
        u_host.dwr(8'h41);
        u_host.idle();
        `CHK({gnd, vgen, bias, ac}, {3'b011, 7'h06})
        u_host.cmd(8'h04);
        u_host.dwr(8'h42);
        u_host.idle();
        `CHK(ac, 7'h05)
        $display("test stepping done");
        u_host.cmd(8'h07);
        u_host.dwr(8'h43);
        u_host.idle();
        `CHK({shift, ac}, {7'h7f, 7'h06})
        u_host.rd(CLE_OFF_DATA, q);
        u_host.cmd(8'h40);
        u_host.dwr(8'h1f);
        u_host.idle();
        `CHK(shift, 7'h7f)
        u_host.cmd(8'h02);
        u_host.idle();
        `CHK({shift, ac}, 14'h0)
        u_host.rd(CLE_OFF_CONFIG, q);
        `CHK(q[8:7], 2'b11)
        $display("test shift and home done");
        u_host.cmd(8'h05);
        u_host.cmd(8'h80);
        u_host.dwr(8'h44);
        u_host.idle();
        `CHK(shift, 7'h01)
        u_host.cmd(8'h01);
        u_host.rd(CLE_OFF_STATUS, q);
        `CHK(q[7], 1'b1)
        u_host.wr(CLE_OFF_DATA, 8'h55);
        u_host.idle();
        `CHK({shift, ac}, 14'h0)
        u_host.rd(CLE_OFF_CONFIG, q);
        `CHK(q[8:7], 2'b11)
        u_host.cmd(8'h80);
        u_host.idle();
        u_host.rd(CLE_OFF_DATA, q);
        u_host.idle();
        u_host.rd(CLE_OFF_DATA, q);
        `CHK(q[7:0], CLE_BLANK_CHAR)
        $display("test clear done");
        u_host.cmd(8'h08);
        u_host.idle();
        `CHK({gnd, vgen, bias}, 3'b100)
        repeat (4) @(posedge clk_i);
        `CHK(stop_ok, 1'b1)
        u_host.cmd(8'h85);
        u_host.idle();
        `CHK(ac, 7'h05)
        $display("test power-down done");
        for (int i = 0; i < 9; i++) begin
            u_host.cmd(cfg_cmd[i]);
            u_host.idle();
            u_host.rd(CLE_OFF_CONFIG, q);
            `CHK(q[6:0], cfg_exp[i])
            `CHK(layout, lay_exp[i])
        end
        u_host.cmd(8'h0f);
        u_host.idle();
        u_host.rd(CLE_OFF_CONFIG, q);
        `CHK(q[11:9], 3'b111)
        `CHK(layout[2:0], 3'b000)
        u_host.cmd(8'h21);
        u_host.cmd(8'h08);
        u_host.cmd(8'h20);
        u_host.idle();
        `CHK({gnd, layout[1:0]}, 3'b011)
        blink_was = blink;
        repeat (8) @(posedge clk_i);
        `CHK(blink, !blink_was)
        u_host.cmd(8'h40);
        `CHK({layout[1:0], blink}, 3'b000)
        u_host.wr(CLE_OFF_CTRLBYTE, 8'h40);
        u_host.rd(CLE_OFF_STATUS, q);
        `CHK(q[9:8], 2'b11)
        u_host.wr(CLE_OFF_CTRLBYTE, 8'h80);
        u_host.rd(CLE_OFF_STATUS, q);
        `CHK(q[9:8], 2'b00)
        $display("test configuration done");
        results();
    end
endmodule
